// ### rtl/wdg_top.sv
/*
 * Watchdog with halt control: 7-bit down counter, activate bit, prescaler,
 * halt / active-halt handling and reset pulse generation.
 * Assumes all inputs come from logic on sys_clk (cpu core, option byte
 * latches, clock controller), so none of them is synchronised here.
 */
`include "wdg_params.svh"
`default_nettype none

module wdg_top #(
	parameter int PRESCALE = `WDG_PRESCALE // oscillator clocks per count
) (
	input  wire logic                sys_clk,        // 40 MHz clock
	input  wire logic                arst_n,         // async reset
	input  wire wdg_pkg::wdg_bus_type bus,           // register request
	output var  logic [7:0]          rdata,          // read data
	input  wire wdg_pkg::wdg_opt_type opt,           // option levels
	input  wire wdg_pkg::wdg_pwr_type pwr,           // power events
	output var  logic                wdg_rst_n,      // reset pin drive
	output var  logic                halt_ack,       // halt entered
	output var  logic                active_halt_ack // active halt entered
);

	// -------------------------------------------------------------------
	// local sizes and decoders
	// -------------------------------------------------------------------

	localparam int PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

	// shared address decode for reads and writes
	function automatic logic is_ctrl(input logic [7:0] addr);
		is_ctrl = (addr == `WDG_CTRL_ADDR);
	endfunction

	// restart delay chosen by option, minus one for count to zero
	function automatic logic [11:0] dly_load(input logic long_sel);
		dly_load = long_sel ? 12'(`WDG_DLY_LONG - 1) : 12'(`WDG_DLY_SHORT - 1);
	endfunction

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------

	wdg_pkg::wdg_mode_type mode_reg;
	wdg_pkg::wdg_mode_type mode_next;
	logic [PRE_W-1:0]      pre_reg;
	logic [6:0]            count_reg;
	logic                  activate_reg;
	logic [11:0]           dly_reg;
	logic [4:0]            pulse_reg;
	logic [4:0]            pulse_next;
	logic                  rst_n_reg;
	logic                  halt_reg;
	logic                  ahalt_reg;
	logic [7:0]            rdata_reg;

	logic ctrl_wr;
	logic ctrl_rd;
	logic armed;
	logic running;
	logic tick;
	logic halt_go;
	logic halt_rst;
	logic halt_plain;
	logic expire;
	logic sw_rst;
	logic trigger;

	// -------------------------------------------------------------------
	// decode of events
	// -------------------------------------------------------------------

	// slow and wait are not seen here: counting follows run
	assign ctrl_wr  = bus.wr && is_ctrl(bus.addr);
	assign ctrl_rd  = bus.rd && is_ctrl(bus.addr);
	assign armed    = activate_reg || opt.hw_watchdog;
	assign running  = (mode_reg == wdg_pkg::WDG_RUN);
	assign tick     = running && (pre_reg == PRE_W'(PRESCALE - 1));
	assign halt_go  = pwr.halt_req && running;

	// halt decision from rtc enable and halt-reset option
	assign halt_rst   = halt_go && !pwr.rtc_irq_enable && opt.halt_reset_option;
	assign halt_plain = halt_go && !pwr.rtc_irq_enable && !opt.halt_reset_option;

	// expiry only while running, so a frozen halt cannot reset
	// the single step taken on halt entry never resets either
	assign expire = tick && armed && (count_reg == `WDG_EXPIRE_CNT)
		&& !halt_plain;

	// writing top bit low while armed kills the chip at once
	assign sw_rst = ctrl_wr && !bus.wdata[`WDG_TOP_BIT]
		&& (bus.wdata[`WDG_ACT_BIT] || armed);

	// a pulse already running swallows further causes
	assign trigger = (expire || sw_rst || halt_rst) && (pulse_reg == 5'h0);

	// -------------------------------------------------------------------
	// power state machine
	// -------------------------------------------------------------------

	// reset always lands in start, then the restart delay
	always_comb
	begin
		mode_next = mode_reg;
		unique case (mode_reg)
			wdg_pkg::WDG_START:
			begin
				mode_next = wdg_pkg::WDG_RESTART;
			end
			wdg_pkg::WDG_RESTART:
			begin
				if (dly_reg == 12'h0)
					mode_next = wdg_pkg::WDG_RUN;
			end
			wdg_pkg::WDG_RUN:
			begin
				if (halt_go && pwr.rtc_irq_enable)
					mode_next = wdg_pkg::WDG_AHALT;
				else if (halt_plain)
					mode_next = wdg_pkg::WDG_HALT;
			end
			wdg_pkg::WDG_HALT:
			begin
				if (pwr.ext_irq)
					mode_next = wdg_pkg::WDG_RESTART;
			end
			wdg_pkg::WDG_AHALT:
			begin
				if (pwr.ext_irq || pwr.rtc_wake)
					mode_next = wdg_pkg::WDG_RUN;
			end
		endcase
	end

	// mode register
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			mode_reg <= wdg_pkg::WDG_START;
		else
			mode_reg <= mode_next;
	end

	// restart delay counter, loaded on start and on external wake
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			dly_reg <= 12'h0;
		else if (mode_reg == wdg_pkg::WDG_START)
			dly_reg <= dly_load(opt.long_delay);
		else if (mode_reg == wdg_pkg::WDG_HALT && pwr.ext_irq)
			dly_reg <= dly_load(opt.long_delay);
		else if (mode_reg == wdg_pkg::WDG_RESTART && dly_reg != 12'h0)
			dly_reg <= dly_reg - 12'h1;
	end

	// -------------------------------------------------------------------
	// prescaler and counter
	// -------------------------------------------------------------------

	// prescaler freezes outside run; writes leave it alone, so the first
	// period after a refresh is shorter by an unknown amount
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			pre_reg <= '0;
		else if (tick)
			pre_reg <= '0;
		else if (running)
			pre_reg <= pre_reg + PRE_W'(1);
	end

	// counter: write wins, then run tick, then single halt step
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			count_reg <= 7'(`WDG_CTRL_RESET & 8'h7f);
		else if (ctrl_wr)
			count_reg <= bus.wdata[6:0];
		else if (tick)
			count_reg <= count_reg - `WDG_ONE_CNT;
		else if (halt_plain)
			count_reg <= count_reg - `WDG_ONE_CNT;
	end

	// activate bit: only a reset clears it, a written zero is ignored
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			activate_reg <= 1'b0;
		else if (ctrl_wr && bus.wdata[`WDG_ACT_BIT])
			activate_reg <= 1'b1;
	end

	// -------------------------------------------------------------------
	// reset pulse
	// -------------------------------------------------------------------

	// fixed length pulse; the chip reset it causes also clears us
	always_comb
	begin
		if (trigger)
			pulse_next = 5'(`WDG_PULSE_CYC);
		else if (pulse_reg != 5'h0)
			pulse_next = pulse_reg - 5'h1;
		else
			pulse_next = 5'h0;
	end

	// pin stays low while the count is nonzero
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pulse_reg <= 5'h0;
			rst_n_reg <= 1'b1;
		end
		else
		begin
			pulse_reg <= pulse_next;
			rst_n_reg <= (pulse_next == 5'h0);
		end
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------

	// halt acknowledges follow the next state so they align with mode_reg
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			halt_reg  <= 1'b0;
			ahalt_reg <= 1'b0;
		end
		else
		begin
			halt_reg  <= (mode_next == wdg_pkg::WDG_HALT);
			ahalt_reg <= (mode_next == wdg_pkg::WDG_AHALT);
		end
	end

	// read data valid one cycle, zero otherwise and for other addresses
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_reg <= 8'h0;
		else if (ctrl_rd)
			rdata_reg <= {activate_reg, count_reg};
		else
			rdata_reg <= 8'h0;
	end

	assign rdata           = rdata_reg;
	assign wdg_rst_n       = rst_n_reg;
	assign halt_ack        = halt_reg;
	assign active_halt_ack = ahalt_reg;

	// -------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------

	default clocking cb @(posedge sys_clk);
	endclocking

	default disable iff (!arst_n);

	hold_active_halt_a: assert property (
		(mode_reg == wdg_pkg::WDG_AHALT && !ctrl_wr) |=> $stable(count_reg))
		else $error("counter moved in active halt");

	halt_no_reset_a: assert property (
		(mode_reg == wdg_pkg::WDG_HALT) |-> !expire ##1 $stable(pre_reg))
		else $error("halt not frozen");

	halt_step_a: assert property (
		(halt_plain && !ctrl_wr) |=> count_reg == $past(count_reg) - `WDG_ONE_CNT
		&& mode_reg == wdg_pkg::WDG_HALT)
		else $error("halt entry step wrong");

	halt_reset_a: assert property (
		(halt_rst && pulse_reg == 5'h0) |=> !wdg_rst_n && mode_reg == wdg_pkg::WDG_RUN)
		else $error("halt option reset missing");

	wake_active_a: assert property (
		(mode_reg == wdg_pkg::WDG_AHALT && (pwr.ext_irq || pwr.rtc_wake))
		|=> running ##1 running)
		else $error("active halt wake not immediate");

	restart_load_a: assert property (
		(mode_reg == wdg_pkg::WDG_HALT && pwr.ext_irq)
		|=> mode_reg == wdg_pkg::WDG_RESTART && dly_reg == dly_load($past(opt.long_delay)))
		else $error("restart delay not loaded");

	restart_end_a: assert property (
		(mode_reg == wdg_pkg::WDG_RESTART && dly_reg != 12'h0)
		|=> mode_reg == wdg_pkg::WDG_RESTART && dly_reg == $past(dly_reg) - 12'h1)
		else $error("restart ended early");

	expire_reset_a: assert property (
		(expire && pulse_reg == 5'h0) |=> !wdg_rst_n && count_reg == 7'h3f)
		else $error("expiry gave no reset");

	free_run_a: assert property (
		(tick && !armed && !ctrl_wr && !halt_rst && pulse_reg == 5'h0)
		|=> count_reg == $past(count_reg) - `WDG_ONE_CNT && wdg_rst_n)
		else $error("counter stalled or reset while disarmed");

	sw_reset_a: assert property (
		(ctrl_wr && bus.wdata[`WDG_ACT_BIT] && !bus.wdata[`WDG_TOP_BIT] && pulse_reg == 5'h0)
		|=> !wdg_rst_n)
		else $error("software reset missing");

	act_sticky_a: assert property (
		activate_reg |=> activate_reg)
		else $error("activate bit cleared");

	pulse_width_a: assert property (
		$fell(wdg_rst_n) |-> ##19 !wdg_rst_n ##1 wdg_rst_n)
		else $error("reset pulse width wrong");

	write_load_a: assert property (
		ctrl_wr |=> count_reg == $past(bus.wdata[6:0])
		&& (pre_reg != '0 || $past(pre_reg) == '0 || $past(tick)))
		else $error("write did not load counter");

	halt_quiet_a: assert property (
		(halt_plain && !ctrl_wr && pulse_reg == 5'h0) |=> wdg_rst_n)
		else $error("halt entry gave a reset");

	read_back_a: assert property (
		ctrl_rd |=> rdata == {$past(activate_reg), $past(count_reg)})
		else $error("read data not the live register");

	hw_expire_a: assert property (
		(tick && opt.hw_watchdog && !activate_reg && count_reg == `WDG_EXPIRE_CNT
		&& !halt_plain && pulse_reg == 5'h0) |=> !wdg_rst_n)
		else $error("hardware option did not arm");

	expire_cv: cover property (expire ##1 !wdg_rst_n);
	halt_wake_cv: cover property (halt_ack ##[1:20] mode_reg == wdg_pkg::WDG_RESTART);
	ahalt_wake_cv: cover property (active_halt_ack ##[1:20] running);
	sw_reset_cv: cover property (sw_rst ##1 !wdg_rst_n);

endmodule

`default_nettype wire

// ### rtl/wdg_params.svh
/*
 * Constants of the halt-aware watchdog: register map, reset values, timing.
 * Assumes the includer runs on a 40 MHz sys_clk that also serves as the
 * oscillator clock and the CPU clock.
 */
`ifndef WDG_PARAMS_SVH
`define WDG_PARAMS_SVH

// -----------------------------------------------------------------------
// What this block does
// - slow and wait modes leave watchdog untouched
// - plain halt: one decrement, then frozen, no reset
// - external wake from halt: restart after delay
// - reset ends halt: disabled unless hardware watchdog
// - halt with reset option set and rtc disabled gives reset
// - rtc enabled: active halt, counter holds
// - wake from active halt resumes counting at once
// - reset ends active halt: restart after delay
// - hardware watchdog: always armed, activate bit ignored
// - control register reads 7Fh after reset
// - activate bit set by write, cleared by reset
// - counter bits decrement every 16384 clocks
// - armed step 40h to 3Fh issues reset
// - counter runs even when not activated
// - write with activate, top bit clear resets
// - watchdog reset pulls reset pin about 500ns
// -----------------------------------------------------------------------

// register map and fields
`define WDG_CTRL_ADDR   8'h2a
`define WDG_CTRL_RESET  8'h7f
`define WDG_ACT_BIT     7
`define WDG_TOP_BIT     6
`define WDG_EXPIRE_CNT  7'h40
`define WDG_ONE_CNT     7'h01

// timing
`define WDG_PRESCALE    16384
`define WDG_DLY_SHORT   256
`define WDG_DLY_LONG    4096
`define WDG_CLK_NS      25
`define WDG_PULSE_NS    500
`define WDG_PULSE_CYC   ((`WDG_PULSE_NS) / (`WDG_CLK_NS))

`endif

// ### rtl/wdg_pkg.sv
/*
 * Types shared by the watchdog: power mode states and signal bundles.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package wdg_pkg;

	// watchdog power state
	typedef enum logic [2:0] {WDG_START, WDG_RESTART, WDG_RUN, WDG_HALT, WDG_AHALT} wdg_mode_type;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} wdg_bus_type;

	// option byte levels
	typedef struct packed {
		logic hw_watchdog;
		logic halt_reset_option;
		logic long_delay;
	} wdg_opt_type;

	// cpu power control events
	typedef struct packed {
		logic halt_req;
		logic ext_irq;
		logic rtc_wake;
		logic rtc_irq_enable;
	} wdg_pwr_type;

endpackage

`default_nettype wire

// ### tb/wdg_cpu_model.sv
/*
 * cpu core power-mode model: halt requests and wake events.
 * assumes it shares the 40 MHz sys_clk of the watchdog.
 */
`default_nettype none

module wdg_cpu_model (
	input  wire logic                 sys_clk, // cpu clock
	output var  wdg_pkg::wdg_pwr_type pwr      // power events
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle until a task asks for something
	initial pwr = '0;

	// halt instruction: enable level set beside the one-cycle request
	task automatic halt(input logic irq_en);
		@(posedge sys_clk);
		pwr.rtc_irq_enable <= irq_en;
		pwr.halt_req       <= 1'b1;
		@(posedge sys_clk);
		pwr.halt_req <= 1'b0;
	endtask

	// wake pulse from rtc or external line, enable dropped after it
	task automatic wake(input logic rtc);
		@(posedge sys_clk);
		pwr.rtc_wake <= rtc;
		pwr.ext_irq  <= !rtc;
		@(posedge sys_clk);
		pwr.rtc_wake       <= 1'b0;
		pwr.ext_irq        <= 1'b0;
		pwr.rtc_irq_enable <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ### tb/wdg_tb_top.sv
/*
 * self-checking bench of the halt-aware watchdog.
 * assumes wdg_top, wdg_pkg and the cpu model; short prescale of 16.
 */
`include "wdg_params.svh"
`default_nettype none

module wdg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PS = 16; // short prescale keeps the run brief
	logic                 sys_clk;
	logic                 arst_n;
	wdg_pkg::wdg_bus_type bus;
	wdg_pkg::wdg_opt_type opt;
	wdg_pkg::wdg_pwr_type pwr;
	logic [7:0]           rdata;
	logic                 wdg_rst_n;
	logic                 halt_ack;
	logic                 active_halt_ack;
	int                   failures;
	int                   checks;
	logic [7:0]           v;
	logic [7:0]           w;
	int                   k;

	wdg_top #(.PRESCALE(PS)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus),
		.rdata(rdata), .opt(opt), .pwr(pwr), .wdg_rst_n(wdg_rst_n),
		.halt_ack(halt_ack), .active_halt_ack(active_halt_ack));
	wdg_cpu_model cpu (.sys_clk(sys_clk), .pwr(pwr));

	// ----------------------------------------
	// clock, tasks
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask

	// the count may have stepped once since it was loaded
	function automatic logic [7:0] near(input logic [7:0] seen, input logic [7:0] exp);
		return (seen === exp - 8'h01) ? seen : exp;
	endfunction

	// bounded wait for the pin pulse, then its low time in cycles
	task automatic pulse(input int bound);
		int n;
		// step off the edge, a pulse launched by the last request shows now
		#1;
		n = 0;
		while (wdg_rst_n !== 1'b0 && n < bound)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk("pin_low", {7'h0, wdg_rst_n}, 8'h00);
		n = 0;
		while (wdg_rst_n === 1'b0 && n < 40)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk("pulse_len", n[7:0], 8'(`WDG_PULSE_CYC));
	endtask

	// reset, then the count must sit still through the restart delay
	task automatic do_rst(input logic ld);
		@(posedge sys_clk);
		opt.long_delay <= ld;
		arst_n         <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(8'h2a, v);
		chk("ctrl_reset", v, `WDG_CTRL_RESET);
		repeat (ld ? 4000 : 200) @(posedge sys_clk);
		rd(8'h2a, v);
		chk("ctrl_held", v, `WDG_CTRL_RESET);
		repeat (ld ? 200 : 100) @(posedge sys_clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		void'($urandom(9419));
		arst_n   = 1'b0;
		bus      = '0;
		opt      = '0;
		failures = 0;
		checks   = 0;
		do_rst(1'b0);
		rd(8'h2b, v);
		chk("unmapped", v, 8'h00);
		wr(8'h2b, 8'h80);
		rd(8'h2a, v);
		chk("unmapped_wr", {7'h0, v[7]}, 8'h00);
		// random loads and spans, never armed
		repeat (4)
		begin
			w = {2'b01, 6'($urandom)};
			k = 1 + $urandom % 4;
			wr(8'h2a, w);
			rd(8'h2a, v);
			chk("load", v, near(v, w));
			repeat (PS * k - 2) @(posedge sys_clk);
			rd(8'h2a, w);
			chk("count", w, v - 8'(k));
		end
		wr(8'h2a, 8'h41);
		repeat (40) @(posedge sys_clk);
		chk("no_reset", {7'h0, wdg_rst_n}, 8'h01);
		wr(8'h2a, 8'hc5);
		rd(8'h2a, v);
		chk("arm", v, near(v, 8'hc5));
		wr(8'h2a, 8'h45);
		rd(8'h2a, v);
		chk("sticky", {7'h0, v[7]}, 8'h01);
		wr(8'h2a, 8'hc1);
		pulse(40);
		do_rst(1'b0);
		wr(8'h2a, 8'hbf);
		pulse(4);
		// plain halt, external wake
		do_rst(1'b0);
		wr(8'h2a, 8'hff);
		cpu.halt(1'b0);
		rd(8'h2a, v);
		chk("halt_ack", {7'h0, halt_ack}, 8'h01);
		chk("halt_step", v, near(v, 8'hfe));
		repeat (PS * 4) @(posedge sys_clk);
		rd(8'h2a, w);
		chk("halt_frozen", w, v);
		cpu.wake(1'b0);
		repeat (200) @(posedge sys_clk);
		rd(8'h2a, w);
		chk("halt_left", {7'h0, halt_ack}, 8'h00);
		chk("restart_hold", w, v);
		repeat (100) @(posedge sys_clk);
		rd(8'h2a, w);
		chk("restart_run", {7'h0, w !== v}, 8'h01);
		// halt with the reset option set
		do_rst(1'b0);
		opt.halt_reset_option <= 1'b1;
		cpu.halt(1'b0);
		pulse(4);
		chk("no_halt", {7'h0, halt_ack}, 8'h00);
		// active halt, both wake sources, reset option left on
		for (int s = 0; s < 2; s++)
		begin
			do_rst(1'b0);
			wr(8'h2a, 8'hff);
			cpu.halt(1'b1);
			rd(8'h2a, v);
			chk("ahalt_ack", {7'h0, active_halt_ack}, 8'h01);
			repeat (PS * 4) @(posedge sys_clk);
			rd(8'h2a, w);
			chk("ahalt_frozen", w, v);
			cpu.wake(s[0]);
			rd(8'h2a, v);
			repeat (PS * 2 - 2) @(posedge sys_clk);
			rd(8'h2a, w);
			chk("ahalt_resume", w, v - 8'h02);
		end
		// reset out of active halt, long restart delay
		cpu.halt(1'b1);
		do_rst(1'b1);
		rd(8'h2a, v);
		chk("long_restart_run", {7'h0, v !== 8'h7f}, 8'h01);
		// hardware option arms without the activate bit
		opt.hw_watchdog <= 1'b1;
		do_rst(1'b0);
		pulse(1300);
		close_out();
	end

	// hang guard, far beyond the expected run length
	initial
	begin
		repeat (40000) @(posedge sys_clk);
		failures++;
		close_out();
	end
endmodule

`default_nettype wire
